// File: spc_playback_clocking.sv
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "spc_regs.svh"

// Functional notes
// - Address counter runs on data clock (sample clock over interpolation)
// - Integer divider from one to four
// - Interpolation one, two or four
// - Sample rate equals input clock over divider
// - Divider times interpolation never above four
// - Latency fixed per setting pair
// - First sample only after full latency; sample ticks, memory reads and address steps already run during latency
// - Trigger active above chosen threshold
// - Eight megaword memory, sequential addressing
// - Calibration command starts calibration sequence
// - Main indicator shows module mode
// - Gate indicator shows relay state, except red during channel calibration
module spc_playback_clocking #(
	parameter int ADDR_W     = 23,
	parameter int CAL_CYCLES = `SPC_CAL_CYCLES
) (
	input  wire logic              core_clk,
	input  wire logic              srst,
	input  wire spc_pkg::spc_bus_req_t bus_req,
	output logic [31:0]            rdata,
	input  wire logic              user_clk_pin,
	input  wire logic              trig_above_0v_pin,
	input  wire logic              trig_above_1v_pin,
	input  wire logic              selftest_error,
	input  wire logic              init_busy,
	output logic                   sample_tick,
	output logic                   data_tick,
	output logic [ADDR_W-1:0]      mem_addr,
	output logic                   mem_rd,
	output logic                   first_sample,
	output logic                   gate_close,
	output logic                   trig_active,
	output spc_pkg::spc_led_t      main_led,
	output spc_pkg::spc_led_t      gate_led,
	output logic                   irq
);
	import spc_pkg::*;

	initial begin
		if (ADDR_W < 4 || ADDR_W > 23)
			$error("ADDR_W out of range");
		if (CAL_CYCLES < 1)
			$error("CAL_CYCLES must be positive");
	end

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic pair_ok(input logic [2:0] d, input logic [2:0] i);
		logic [5:0] p;
		p = 6'(d) * 6'(i);
		pair_ok = (d != 3'h0) && (i == 3'h1 || i == 3'h2 || i == 3'h4)
			&& (p <= 6'(`SPC_MAX_PRODUCT));
	endfunction

	function automatic logic [9:0] latency_of(input spc_pair_t p);
		case ({p.interp, p.div})
			6'o11:   latency_of = `SPC_LAT_I1_D1;
			6'o12:   latency_of = `SPC_LAT_I1_D2;
			6'o13:   latency_of = `SPC_LAT_I1_D3;
			6'o14:   latency_of = `SPC_LAT_I1_D4;
			6'o21:   latency_of = `SPC_LAT_I2_D1;
			6'o22:   latency_of = `SPC_LAT_I2_D2;
			6'o41:   latency_of = `SPC_LAT_I4_D1;
			default: latency_of = `SPC_LAT_I1_D1;
		endcase
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] pin_s1_reg;
	logic [2:0] pin_s2_reg;
	logic       uclk_prev_reg;

	always_ff @(posedge core_clk) begin
		pin_s1_reg    <= {trig_above_1v_pin, trig_above_0v_pin, user_clk_pin};
		pin_s2_reg    <= pin_s1_reg;
		uclk_prev_reg <= pin_s2_reg[0];
	end

	// ****************************************
	// Registers
	// ****************************************
	typedef enum {
		ST_CONFIG,
		ST_CAL,
		ST_LATENCY,
		ST_PLAY,
		ST_ERROR
	} spc_state_t;

	spc_state_t        state_reg, state_next;
	logic [6:0]        ctrl_reg, ctrl_next;
	spc_pair_t         pair_reg, pair_next;
	logic [3:0]        istat_reg, istat_next;
	logic [3:0]        imask_reg, imask_next;
	logic [31:0]       rdata_reg, rdata_next;
	logic [2:0]        div_cnt_reg, div_cnt_next;
	logic [1:0]        int_cnt_reg, int_cnt_next;
	logic [9:0]        lat_cnt_reg, lat_cnt_next;
	logic [31:0]       cal_cnt_reg, cal_cnt_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic              stick_reg, stick_next;
	logic              dtick_reg, dtick_next;
	logic              first_reg, first_next;

	logic clk_edge;
	logic samp_ev;
	logic data_ev;
	logic [3:0] ev;
	logic wr_ctrl, wr_cfg, wr_istat, wr_imask;
	logic [2:0] req_div, req_interp;

	assign wr_ctrl    = bus_req.wr && bus_req.addr == `SPC_OFF_CTRL;
	assign wr_cfg     = bus_req.wr && bus_req.addr == `SPC_OFF_CLKCFG;
	assign wr_istat   = bus_req.wr && bus_req.addr == `SPC_OFF_IRQ_STAT;
	assign wr_imask   = bus_req.wr && bus_req.addr == `SPC_OFF_IRQ_MASK;
	assign req_div    = bus_req.wdata[`SPC_CFG_DIV_LSB +: 3];
	assign req_interp = bus_req.wdata[`SPC_CFG_INTERP_LSB +: 3];

	// Applied clock edge: user pin or backplane (core clock) edge
	assign clk_edge = ctrl_reg[`SPC_CTRL_EXTCLK]
		? (pin_s2_reg[0] && !uclk_prev_reg) : 1'b1;
	// Sample edge every divider count of applied edges
	assign samp_ev = clk_edge && div_cnt_reg == pair_reg.div - 3'h1;
	// Data edge every interpolation count of sample edges
	assign data_ev = samp_ev && {1'b0, int_cnt_reg} == pair_reg.interp - 3'h1;

	always_comb begin
		state_next   = state_reg;
		ctrl_next    = ctrl_reg;
		pair_next    = pair_reg;
		imask_next   = imask_reg;
		div_cnt_next = div_cnt_reg;
		int_cnt_next = int_cnt_reg;
		lat_cnt_next = lat_cnt_reg;
		cal_cnt_next = cal_cnt_reg;
		addr_next    = addr_reg;
		stick_next   = 1'b0;
		dtick_next   = 1'b0;
		first_next   = 1'b0;
		ev           = 4'h0;
		rdata_next   = 32'h0;

		if (wr_ctrl) begin
			ctrl_next = bus_req.wdata[6:0];
			// Internal clock forbids external trigger
			if (!bus_req.wdata[`SPC_CTRL_EXTCLK])
				ctrl_next[`SPC_CTRL_EXTTRIG] = 1'b0;
		end
		if (wr_cfg) begin
			if (state_reg == ST_CONFIG && pair_ok(req_div, req_interp)) begin
				pair_next.div    = req_div;
				pair_next.interp = req_interp;
			end else begin
				ev[`SPC_IRQ_REJECT] = 1'b1;
			end
		end
		if (wr_imask)
			imask_next = bus_req.wdata[3:0];

		if (clk_edge)
			div_cnt_next = samp_ev ? 3'h0 : div_cnt_reg + 3'h1;
		if (samp_ev)
			int_cnt_next = data_ev ? 2'h0 : int_cnt_reg + 2'h1;

		case (state_reg)
			ST_CONFIG: begin
				addr_next = '0;
				if (ctrl_next[`SPC_CTRL_CAL]) begin
					state_next   = ST_CAL;
					cal_cnt_next = 32'h0;
				end else if (ctrl_next[`SPC_CTRL_MEAS]) begin
					state_next   = ST_LATENCY;
					lat_cnt_next = latency_of(pair_reg);
					div_cnt_next = 3'h0;
					int_cnt_next = 2'h0;
				end
			end
			ST_CAL: begin
				cal_cnt_next = cal_cnt_reg + 32'h1;
				if (cal_cnt_reg == 32'(CAL_CYCLES - 1)) begin
					state_next = ST_CONFIG;
					ctrl_next[`SPC_CTRL_CAL]   = 1'b0;
					ctrl_next[`SPC_CTRL_CHCAL] = 1'b0;
					ev[`SPC_IRQ_CALDONE] = 1'b1;
				end
			end
			ST_LATENCY, ST_PLAY: begin
				stick_next = samp_ev;
				dtick_next = data_ev;
				if (data_ev) begin
					addr_next = addr_reg + 1'b1;
					if (&addr_reg)
						ev[`SPC_IRQ_WRAP] = 1'b1;
				end
				if (state_reg == ST_LATENCY && clk_edge) begin
					if (lat_cnt_reg == 10'd1) begin
						state_next = ST_PLAY;
						first_next = 1'b1;
						ev[`SPC_IRQ_FIRST] = 1'b1;
					end else begin
						lat_cnt_next = lat_cnt_reg - 10'd1;
					end
				end
				if (!ctrl_next[`SPC_CTRL_MEAS])
					state_next = ST_CONFIG;
			end
			ST_ERROR: state_next = ST_ERROR;
			default:  state_next = ST_CONFIG;
		endcase
		if (selftest_error)
			state_next = ST_ERROR;

		// Set wins over write-one clear
		istat_next = (istat_reg & ~(wr_istat ? bus_req.wdata[3:0] : 4'h0)) | ev;

		if (bus_req.rd) begin
			case (bus_req.addr)
				`SPC_OFF_CTRL:     rdata_next = {25'h0, ctrl_reg};
				`SPC_OFF_CLKCFG:   rdata_next = {25'h0, pair_reg.interp, 1'b0, pair_reg.div};
				`SPC_OFF_STATUS:   rdata_next = {28'h0, trig_active, 3'(state_reg)};
				`SPC_OFF_IRQ_STAT: rdata_next = {28'h0, istat_reg};
				`SPC_OFF_IRQ_MASK: rdata_next = {28'h0, imask_reg};
				`SPC_OFF_ADDR:     rdata_next = 32'(addr_reg);
				default:           rdata_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_reg   <= ST_CONFIG;
			ctrl_reg    <= 7'h0;
			pair_reg    <= '{div: `SPC_RST_DIV, interp: `SPC_RST_INTERP};
			istat_reg   <= 4'h0;
			imask_reg   <= 4'h0;
			rdata_reg   <= 32'h0;
			div_cnt_reg <= 3'h0;
			int_cnt_reg <= 2'h0;
			lat_cnt_reg <= 10'h0;
			cal_cnt_reg <= 32'h0;
			addr_reg    <= '0;
			stick_reg   <= 1'b0;
			dtick_reg   <= 1'b0;
			first_reg   <= 1'b0;
		end else begin
			state_reg   <= state_next;
			ctrl_reg    <= ctrl_next;
			pair_reg    <= pair_next;
			istat_reg   <= istat_next;
			imask_reg   <= imask_next;
			rdata_reg   <= rdata_next;
			div_cnt_reg <= div_cnt_next;
			int_cnt_reg <= int_cnt_next;
			lat_cnt_reg <= lat_cnt_next;
			cal_cnt_reg <= cal_cnt_next;
			addr_reg    <= addr_next;
			stick_reg   <= stick_next;
			dtick_reg   <= dtick_next;
			first_reg   <= first_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign rdata        = rdata_reg;
	assign sample_tick  = stick_reg;
	assign data_tick    = dtick_reg;
	assign mem_addr     = addr_reg;
	assign mem_rd       = dtick_reg;
	assign first_sample = first_reg;
	assign gate_close   = ctrl_reg[`SPC_CTRL_GATE];
	assign irq          = |(istat_reg & imask_reg);
	// Threshold select picks comparator
	assign trig_active  = ctrl_reg[`SPC_CTRL_THRESH] ? pin_s2_reg[2] : pin_s2_reg[1];

	always_comb begin
		if (state_reg == ST_ERROR || state_reg == ST_CAL || init_busy)
			main_led = SPC_LED_RED;
		else if (state_reg == ST_LATENCY || state_reg == ST_PLAY)
			main_led = SPC_LED_GREEN;
		else
			main_led = SPC_LED_OFF;
		if (state_reg == ST_CAL && ctrl_reg[`SPC_CTRL_CHCAL])
			gate_led = SPC_LED_RED;
		else if (ctrl_reg[`SPC_CTRL_GATE])
			gate_led = SPC_LED_GREEN;
		else
			gate_led = SPC_LED_OFF;
	end

endmodule
`default_nettype wire

// File: spc_regs.svh
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH

// Register offsets (byte addresses)
`define SPC_OFF_CTRL       8'h00
`define SPC_OFF_CLKCFG     8'h04
`define SPC_OFF_STATUS     8'h08
`define SPC_OFF_IRQ_STAT   8'h0c
`define SPC_OFF_IRQ_MASK   8'h10
`define SPC_OFF_ADDR       8'h14

// Control fields
`define SPC_CTRL_MEAS      0
`define SPC_CTRL_CAL       1
`define SPC_CTRL_EXTCLK    2
`define SPC_CTRL_THRESH    3
`define SPC_CTRL_GATE      4
`define SPC_CTRL_EXTTRIG   5
`define SPC_CTRL_CHCAL     6

// Clock config fields
`define SPC_CFG_DIV_LSB    0
`define SPC_CFG_INTERP_LSB 4

// Interrupt bits
`define SPC_IRQ_REJECT     0
`define SPC_IRQ_FIRST      1
`define SPC_IRQ_CALDONE    2
`define SPC_IRQ_WRAP       3

// Reset values
`define SPC_RST_DIV        3'h1
`define SPC_RST_INTERP     3'h1

// Product limit of divider and interpolation
`define SPC_MAX_PRODUCT    4

// Latency in input clock periods per setting pair
`define SPC_LAT_I1_D1      10'd161
`define SPC_LAT_I1_D2      10'd322
`define SPC_LAT_I1_D3      10'd483
`define SPC_LAT_I1_D4      10'd644
`define SPC_LAT_I2_D1      10'd282
`define SPC_LAT_I2_D2      10'd564
`define SPC_LAT_I4_D1      10'd508

// Calibration duration default in cycles
`define SPC_CAL_CYCLES     1000000

`endif

// File: spc_pkg.sv
package spc_pkg;

	typedef enum logic [1:0] {
		SPC_LED_OFF   = 2'h0,
		SPC_LED_GREEN = 2'h1,
		SPC_LED_RED   = 2'h2
	} spc_led_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} spc_bus_req_t;

	typedef struct packed {
		logic [2:0] div;
		logic [2:0] interp;
	} spc_pair_t;

endpackage

// File: spc_playback_clocking_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checker
// ****
module spc_playback_clocking_chk
	import spc_pkg::*;
#(
	parameter int ADDR_W = 23
) (
	input wire logic     core_clk,
	input wire logic     srst,
	input wire logic     trig_above_0v_pin,
	input wire logic     trig_above_1v_pin,
	input wire logic     selftest_error,
	input wire logic     init_busy,
	input wire logic     data_tick,
	input wire logic     mem_rd,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic     first_sample,
	input wire logic     gate_close,
	input wire logic     trig_active,
	input wire spc_led_t main_led,
	input wire spc_led_t gate_led
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	property p_rd_tick;
		(mem_rd == data_tick) && (!data_tick || mem_addr == ADDR_W'($past(mem_addr) + 1'b1));
	endproperty
	a_rd_tick: assert property (p_rd_tick) else $error("mem_rd off");
	property p_first_pulse;
		first_sample |=> !first_sample;
	endproperty
	a_first_pulse: assert property (p_first_pulse) else $error("long first");
	property p_first_green;
		first_sample |-> main_led == SPC_LED_GREEN;
	endproperty
	a_first_green: assert property (p_first_green) else $error("led not green");
	property p_err_red;
		selftest_error |-> ##2 (main_led == SPC_LED_RED) [*8];
	endproperty
	a_err_red: assert property (p_err_red) else $error("error not red");
	property p_init_red;
		init_busy [*2] |-> main_led == SPC_LED_RED;
	endproperty
	a_init_red: assert property (p_init_red) else $error("init not red");
	property p_trig_hi;
		(trig_above_0v_pin && trig_above_1v_pin) [*4] |-> trig_active;
	endproperty
	a_trig_hi: assert property (p_trig_hi) else $error("trig low");
	property p_trig_lo;
		(!trig_above_0v_pin && !trig_above_1v_pin) [*4] |-> !trig_active;
	endproperty
	a_trig_lo: assert property (p_trig_lo) else $error("trig high");
	property p_gate_green;
		gate_led == SPC_LED_GREEN |-> gate_close;
	endproperty
	a_gate_green: assert property (p_gate_green) else $error("gate led");
endmodule
`default_nettype wire

// File: spc_ext_src.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// User clock and trigger comparators
// ****
module spc_ext_src (
	input  wire logic       run,
	input  wire logic [1:0] trig_lvl,
	output logic            user_clk_pin,
	output logic            trig_above_0v_pin,
	output logic            trig_above_1v_pin
);
	// 25 MHz, stands still outside playback
	initial begin
		user_clk_pin = 1'b0;
		#3;
		forever #20 user_clk_pin = run ? ~user_clk_pin : 1'b0;
	end
	assign trig_above_0v_pin = trig_lvl >= 2'h1;
	assign trig_above_1v_pin = trig_lvl >= 2'h2;
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import spc_pkg::*;
	logic         core_clk, srst, run, init_busy, selftest_error, user_clk_pin;
	logic         trig_above_0v_pin, trig_above_1v_pin, sample_tick, data_tick;
	logic         mem_rd, first_sample, gate_close, trig_active, irq;
	logic [1:0]   trig_lvl;
	logic [31:0]  rdata, q;
	logic [22:0]  mem_addr;
	spc_bus_req_t bus_req;
	spc_led_t     main_led, gate_led;
	int           errors, checked, n, dt, st;
	int           lat[7] = '{161, 322, 483, 644, 282, 564, 508};
	logic [7:0]   pr[7] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h21, 8'h22, 8'h41};
	logic [7:0]   bad[5] = '{8'h24, 8'h42, 8'h31, 8'h10, 8'h15};
	spc_playback_clocking #(.CAL_CYCLES(20)) uut (.core_clk, .srst, .bus_req, .rdata,
		.user_clk_pin, .trig_above_0v_pin, .trig_above_1v_pin, .selftest_error,
		.init_busy, .sample_tick, .data_tick, .mem_addr, .mem_rd, .first_sample,
		.gate_close, .trig_active, .main_led, .gate_led, .irq);
	spc_ext_src ext (.run, .trig_lvl, .user_clk_pin, .trig_above_0v_pin, .trig_above_1v_pin);
	// ****
	// Bus access and compare
	// ****
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		bus_req <= '{a, d, w, ~w};
		@(posedge core_clk);
		bus_req <= '0;
		#1;
		q = rdata;
	endtask
	task automatic chk(input string s, input logic [31:0] v, input logic [31:0] e);
		checked++;
		if (v !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", s, e, v);
		end
	endtask
	task automatic wait_first;
		n = 0;
		while (first_sample !== 1'b1 && n < 1000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
	endtask
	task automatic count(input int c);
		dt = 0;
		st = 0;
		repeat (c) begin
			@(posedge core_clk);
			#1;
			dt += data_tick;
			st += sample_tick;
		end
	endtask
	task automatic end_of_test;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ****
	// Scenarios
	// ****
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		#200000;
		errors++;
		end_of_test();
	end
	initial begin
		srst = 1'b1;
		bus_req = '0;
		{run, init_busy, selftest_error} = 3'h0;
		trig_lvl = 2'h1;
		repeat (8) @(posedge core_clk);
		srst <= 1'b0;
		acc(0, 8'h04, 0);
		chk("pair_rst", q, 32'h11);
		acc(1, 8'h40, 32'h42);
		acc(0, 8'h40, 0);
		chk("unmapped", q, 0);
		foreach (pr[k]) begin
			acc(1, 8'h04, {24'h0, pr[k]});
			acc(0, 8'h04, 0);
			chk("pair", q, {24'h0, pr[k]});
			acc(1, 8'h00, 32'h1);
			wait_first();
			chk("latency", 32'(n >= lat[k] && n <= lat[k] + 2), 1);
			chk("led_meas", main_led, SPC_LED_GREEN);
			q = {9'h0, mem_addr};
			count(48);
			chk("data_rate", dt, 48 / (pr[k][2:0] * pr[k][6:4]));
			chk("sample_rate", st, 48 / pr[k][2:0]);
			chk("addr_step", 32'(mem_addr - q[22:0] - dt[22:0] + 23'h1 <= 23'h2), 1);
			acc(1, 8'h00, 0);
			chk("led_cfg", main_led, SPC_LED_OFF);
			count(1);
			chk("addr_clr", mem_addr, 0);
			acc(0, 8'h14, 0);
			chk("addr_rd", q, 0);
		end
		foreach (bad[k]) begin
			acc(1, 8'h04, {24'h0, bad[k]});
			acc(0, 8'h04, 0);
			chk("keep_pair", q, 32'h41);
			acc(0, 8'h0c, 0);
			chk("reject", q[0], 1);
			acc(1, 8'h0c, 32'h1);
		end
		acc(1, 8'h04, 32'h11);
		acc(1, 8'h00, 32'h1);
		acc(1, 8'h04, 32'h12);
		acc(1, 8'h10, 32'h1);
		chk("irq_on", irq, 1);
		acc(1, 8'h10, 0);
		chk("irq_mask", irq, 0);
		acc(1, 8'h0c, 32'h1);
		acc(0, 8'h0c, 0);
		chk("irq_clr", q[0], 0);
		acc(1, 8'h00, 0);
		acc(1, 8'h00, 32'h2);
		chk("led_cal", main_led, SPC_LED_RED);
		repeat (30) @(posedge core_clk);
		#1;
		chk("led_done", main_led, SPC_LED_OFF);
		acc(0, 8'h0c, 0);
		chk("cal_done", q[2], 1);
		acc(1, 8'h00, 32'h10);
		chk("gate_on", {gate_close, gate_led}, {1'b1, SPC_LED_GREEN});
		acc(1, 8'h00, 32'h52);
		chk("gate_cal", gate_led, SPC_LED_RED);
		acc(1, 8'h00, 32'h20);
		chk("gate_off", gate_led, SPC_LED_OFF);
		acc(0, 8'h00, 0);
		chk("trig_src", q[5], 0);
		chk("trig_0v", trig_active, 1);
		acc(1, 8'h00, 32'h8);
		chk("trig_1v", trig_active, 0);
		trig_lvl <= 2'h2;
		count(5);
		chk("trig_hi", trig_active, 1);
		run <= 1'b1;
		acc(1, 8'h00, 32'h5);
		wait_first();
		count(80);
		chk("ext_rate", st, 20);
		acc(1, 8'h00, 0);
		@(posedge core_clk);
		run <= 1'b0;
		init_busy <= 1'b1;
		count(3);
		chk("led_init", main_led, SPC_LED_RED);
		@(posedge core_clk);
		init_busy <= 1'b0;
		selftest_error <= 1'b1;
		@(posedge core_clk);
		selftest_error <= 1'b0;
		acc(1, 8'h00, 32'h1);
		count(10);
		chk("led_err", main_led, SPC_LED_RED);
		acc(0, 8'h08, 0);
		chk("status_err", q[2:0], 3'h4);
		@(posedge core_clk);
		srst <= 1'b1;
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		count(2);
		chk("led_rst", main_led, SPC_LED_OFF);
		trig_lvl <= 2'h0;
		count(5);
		chk("trig_lo", trig_active, 0);
		end_of_test();
	end
endmodule
bind spc_playback_clocking spc_playback_clocking_chk chk (.core_clk, .srst, .trig_above_0v_pin,
	.trig_above_1v_pin, .selftest_error, .init_busy, .data_tick, .mem_rd, .mem_addr, .first_sample,
	.gate_close, .trig_active, .main_led, .gate_led);
`default_nettype wire
